// ===== core/sdram_ui_port.sv
// What this block does
// (RULE1) Requester presents a flat address with every request it submits.
// (RULE2) Requester drives a three-bit command selecting the operation.
// (RULE3) Request strobe active high; address, command, size, priority sampled together.
// (RULE4) Ready high means a command is taken; strobes while low must be retried.
// (RULE5) Reserved priority, size and self-refresh inputs are tied to zero.
// (RULE6) Read data returns on a bus as wide as the application data.
// (RULE7) Read-valid is high in every cycle carrying valid read data.
// (RULE8) Read-end is high in the cycle with the final read beat.
// (RULE9) Requester supplies write data qualified by a write data strobe.
// (RULE10) A write beat moves only when buffer-ready and strobe are both high.
// (RULE11) Buffer-ready is high only while the write buffer has room.
// (RULE12) Requester marks the final write beat of a request with write-end.
// (RULE13) Requester drives a byte mask with each write beat.
// (RULE14) Runs on the user clock with an active-high synchronous reset output.
// (RULE15) Calibration-complete rises once initialization and calibration are finished.
// (RULE16) Command code 000 is write, 001 is read; others unused.
`default_nettype none
module sdram_ui_port
    import sdram_ui_pkg::*;
(
    input wire logic ref_clk_in,
    input wire logic reset_in,
    input wire logic [sdram_ui_pkg::ADDR_WIDTH-1:0] req_addr_in,
    input wire logic [sdram_ui_pkg::CMD_WIDTH-1:0] req_cmd_in,
    input wire logic req_en_in,
    output logic req_rdy_out,
    input wire logic req_priority_reserved_in,
    input wire logic req_size_reserved_in,
    input wire logic self_refresh_req_reserved_in,
    output logic [sdram_ui_pkg::APP_DATA_WIDTH-1:0] rd_data_out,
    output logic rd_data_end_out,
    output logic rd_data_valid_out,
    input wire logic [sdram_ui_pkg::APP_DATA_WIDTH-1:0] wdf_data_in,
    input wire logic wdf_end_in,
    input wire logic [sdram_ui_pkg::APP_MASK_WIDTH-1:0] wdf_mask_in,
    output logic wdf_rdy_out,
    input wire logic wdf_wren_in,
    output logic calib_complete_out,
    output logic user_side_reset_out
);
    import sdram_ui_pkg::*;

    localparam int WDF_W = APP_DATA_WIDTH + APP_MASK_WIDTH + 1;

    ui_state_t state_ff;
    logic [CALIB_CNT_W-1:0] calib_cnt_ff;
    logic calib_done_ff;
    logic reset_ff;
    logic [MEM_IDX_W-1:0] base_idx_ff;
    logic [BEAT_W-1:0] beat_ff;
    logic [WDF_W-1:0] wdf_mem [WDF_DEPTH];
    logic [WDF_PTR_W-1:0] wdf_wptr_ff;
    logic [WDF_PTR_W-1:0] wdf_rptr_ff;
    logic [WDF_CNT_W-1:0] wdf_cnt_ff;
    logic [APP_DATA_WIDTH-1:0] store_mem [MEM_WORDS];
    logic [APP_DATA_WIDTH-1:0] rd_data_ff;
    logic rd_valid_ff;
    logic rd_end_ff;
    logic take;
    logic push;
    logic pop;
    logic [WDF_W-1:0] head;
    logic head_end;
    logic [APP_MASK_WIDTH-1:0] head_mask;
    logic [APP_DATA_WIDTH-1:0] head_data;
    logic [MEM_IDX_W-1:0] cur_idx;
    logic in_read;
    logic [APP_DATA_WIDTH-1:0] merged_word;

    // Burst end test, shared by both paths and the end flag
    function automatic logic last_beat(input logic [BEAT_W-1:0] beat);
        return beat == BEAT_LAST;
    endfunction

    // Command decode to the state that serves it
    function automatic ui_state_t cmd_target(input logic [CMD_WIDTH-1:0] cmd);
        if (cmd == CMD_WRITE) begin
            return ST_WRITE;
        end else if (cmd == CMD_READ) begin
            return ST_READ;
        end
        return ST_IDLE;
    endfunction

    // Reserved inputs are sampled by nothing; their value has no effect [RULE5]
    assign req_rdy_out = (state_ff == ST_IDLE); // [RULE4]
    assign take = req_en_in && req_rdy_out; // [RULE3] [RULE4]
    assign wdf_rdy_out = calib_done_ff && (wdf_cnt_ff < WDF_CNT_W'(WDF_DEPTH)); // [RULE11]
    assign push = wdf_wren_in && wdf_rdy_out; // [RULE10]
    assign pop = (state_ff == ST_WRITE) && (wdf_cnt_ff != WDF_CNT_RESET);
    assign head = wdf_mem[wdf_rptr_ff];
    assign head_end = head[WDF_W-1];
    assign head_mask = head[APP_DATA_WIDTH +: APP_MASK_WIDTH];
    assign head_data = head[APP_DATA_WIDTH-1:0];
    assign cur_idx = base_idx_ff + MEM_IDX_W'(beat_ff);
    assign in_read = (state_ff == ST_READ);

    // Outputs straight from flops; no logic between register and port
    assign rd_data_out = rd_data_ff; // [RULE6]
    assign rd_data_valid_out = rd_valid_ff;
    assign rd_data_end_out = rd_end_ff;
    assign calib_complete_out = calib_done_ff;
    assign user_side_reset_out = reset_ff;

    // Reset output follows the input one clock later, on the user clock [RULE14]
    always_ff @(posedge ref_clk_in) begin
        reset_ff <= reset_in;
    end

    // Calibration wait: no request or write beat is taken before it ends [RULE15]
    // Counter freezes once done; only a reset starts calibration again
    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            calib_cnt_ff <= CALIB_CNT_RESET;
            calib_done_ff <= 1'b0;
        end else if (!calib_done_ff) begin
            calib_cnt_ff <= calib_cnt_ff + 1'b1;
            calib_done_ff <= (calib_cnt_ff == CALIB_CNT_W'(CALIB_CYCLES - 1));
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            state_ff <= ST_CALIB;
        end else begin
            unique case (state_ff)
                ST_CALIB: begin
                    if (calib_done_ff) begin
                        state_ff <= ST_IDLE;
                    end
                end
                ST_IDLE: begin
                    // Unused codes are taken and dropped so the requester never stalls [RULE16]
                    if (take) begin
                        state_ff <= cmd_target(req_cmd_in);
                    end
                end
                ST_WRITE: begin
                    // Write ends at the marked beat or after the burst length [RULE12]
                    // An empty buffer simply holds the write until data arrives
                    if (pop && (head_end || last_beat(beat_ff))) begin
                        state_ff <= ST_IDLE;
                    end
                end
                ST_READ: begin
                    // One beat per cycle; the read side never stalls
                    if (last_beat(beat_ff)) begin
                        state_ff <= ST_IDLE;
                    end
                end
            endcase
        end
    end

    // Address step of 8: the three low bits select no word [RULE1]
    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            base_idx_ff <= '0;
            beat_ff <= BEAT_RESET;
        end else if (take) begin
            base_idx_ff <= req_addr_in[ADDR_LSB +: MEM_IDX_W];
            beat_ff <= BEAT_RESET;
        end else if (pop || in_read) begin
            beat_ff <= beat_ff + 1'b1;
        end
    end

    // Write data buffer; data may arrive ahead of its command [RULE9] [RULE10]
    // No reset on the array; the pointers and the count decide what is valid
    always_ff @(posedge ref_clk_in) begin
        if (push) begin
            wdf_mem[wdf_wptr_ff] <= {wdf_end_in, wdf_mask_in, wdf_data_in};
        end
    end

    // Count is one bit wider than the pointers, so full and empty differ
    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            wdf_wptr_ff <= WDF_PTR_RESET;
            wdf_rptr_ff <= WDF_PTR_RESET;
            wdf_cnt_ff <= WDF_CNT_RESET;
        end else begin
            if (push) begin
                wdf_wptr_ff <= wdf_wptr_ff + 1'b1;
            end
            if (pop) begin
                wdf_rptr_ff <= wdf_rptr_ff + 1'b1;
            end
            wdf_cnt_ff <= wdf_cnt_ff + WDF_CNT_W'(push) - WDF_CNT_W'(pop);
        end
    end

    // Byte lanes merged first, so one process alone writes the store [RULE13]
    for (genvar b = 0; b < APP_MASK_WIDTH; b++) begin : g_lane
        // Mask bit high keeps the stored byte
        assign merged_word[b*8 +: 8] = head_mask[b] ? store_mem[cur_idx][b*8 +: 8]
            : head_data[b*8 +: 8];
    end

    always_ff @(posedge ref_clk_in) begin
        if (pop) begin
            store_mem[cur_idx] <= merged_word;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            rd_data_ff <= '0;
            rd_valid_ff <= 1'b0;
            rd_end_ff <= 1'b0;
        end else begin
            // Flags lag the state by one flop, so beats show two cycles after a take
            rd_valid_ff <= in_read; // [RULE7]
            rd_end_ff <= in_read && last_beat(beat_ff); // [RULE8]
            if (in_read) begin
                rd_data_ff <= store_mem[cur_idx]; // [RULE6]
            end
        end
    end
endmodule // sdram_ui_port
`default_nettype wire

// ===== common/sdram_ui_pkg.sv
`default_nettype none
package sdram_ui_pkg;
    localparam int ADDR_WIDTH = 29;
    localparam int APP_DATA_WIDTH = 64;
    localparam int APP_MASK_WIDTH = 8;
    localparam int CMD_WIDTH = 3;
    localparam logic [CMD_WIDTH-1:0] CMD_WRITE = 3'h0;
    localparam logic [CMD_WIDTH-1:0] CMD_READ = 3'h1;

    localparam int CLK_PERIOD_PS = 5000;
    localparam int CALIB_TIME_NS = 2000;
    localparam int CALIB_CYCLES = (CALIB_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int CALIB_CNT_W = 9;
    localparam logic [CALIB_CNT_W-1:0] CALIB_CNT_RESET = 9'h000;

    localparam int WDF_DEPTH = 4;
    localparam int WDF_PTR_W = 2;
    localparam int WDF_CNT_W = 3;
    localparam logic [WDF_PTR_W-1:0] WDF_PTR_RESET = 2'h0;
    localparam logic [WDF_CNT_W-1:0] WDF_CNT_RESET = 3'h0;

    localparam int MEM_WORDS = 16;
    localparam int MEM_IDX_W = 4;
    localparam int ADDR_LSB = 3;
    localparam int BEAT_W = 1;
    localparam logic [BEAT_W-1:0] BEAT_LAST = 1'h1;
    localparam logic [BEAT_W-1:0] BEAT_RESET = 1'h0;

    typedef enum logic [1:0] {
        ST_CALIB,
        ST_IDLE,
        ST_WRITE,
        ST_READ
    } ui_state_t;
endpackage
`default_nettype wire

// ===== verification/ui_port_checker_properties.sv
`default_nettype none
module ui_port_checker
    import sdram_ui_pkg::*;
(
    input wire logic ref_clk_in,
    input wire logic reset_in,
    input wire logic [sdram_ui_pkg::CMD_WIDTH-1:0] req_cmd_in,
    input wire logic req_en_in,
    input wire logic req_rdy_out,
    input wire logic rd_data_end_out,
    input wire logic rd_data_valid_out,
    input wire logic wdf_rdy_out,
    input wire logic calib_complete_out,
    input wire logic user_side_reset_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic tk;
    logic rtk;
    assign tk = req_en_in && req_rdy_out;
    assign rtk = tk && req_cmd_in == CMD_READ;
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (reset_in);
    property p_busy; tk && req_cmd_in <= CMD_READ |=> !req_rdy_out; endproperty
    a_busy: assert property (p_busy) else $error("ready after take");
    property p_rdl; rtk |=> !req_rdy_out [*2] ##1 req_rdy_out; endproperty
    a_rdl: assert property (p_rdl) else $error("read busy span");
    property p_bad; tk && req_cmd_in > CMD_READ |=> req_rdy_out; endproperty
    a_bad: assert property (p_bad) else $error("unused code blocked");
    property p_rd; rtk |-> ##2 rd_data_valid_out && !rd_data_end_out
        ##1 rd_data_valid_out && rd_data_end_out; endproperty
    a_rd: assert property (p_rd) else $error("read beats");
    property p_src; rd_data_valid_out && !rd_data_end_out |-> $past(rtk, 2); endproperty
    a_src: assert property (p_src) else $error("stray valid");
    property p_end; rd_data_end_out |-> rd_data_valid_out && $past(rd_data_valid_out); endproperty
    a_end: assert property (p_end) else $error("end misplaced");
    property p_wcal; !calib_complete_out |-> !wdf_rdy_out && !req_rdy_out; endproperty
    a_wcal: assert property (p_wcal) else $error("ready before calib");
    property p_cal; calib_complete_out |=> calib_complete_out; endproperty
    a_cal: assert property (p_cal) else $error("calib dropped");
    property p_urst; $fell(reset_in) |-> user_side_reset_out ##1 !user_side_reset_out; endproperty
    a_urst: assert property (p_urst) else $error("reset out timing");
    c_rd: cover property (rtk);
    c_bad: cover property (tk && req_cmd_in > CMD_READ);
    c_full: cover property (calib_complete_out && !wdf_rdy_out);
endmodule // ui_port_checker
bind sdram_ui_port ui_port_checker chk (.ref_clk_in, .reset_in, .req_cmd_in, .req_en_in,
    .req_rdy_out, .rd_data_end_out, .rd_data_valid_out, .wdf_rdy_out, .calib_complete_out,
    .user_side_reset_out);
`default_nettype wire

// ===== verification/ui_requester.sv
`default_nettype none
module ui_requester
    import sdram_ui_pkg::*;
(
    input wire logic clk_in,
    input wire logic rdy_in,
    input wire logic wdf_rdy_in,
    output logic [sdram_ui_pkg::ADDR_WIDTH-1:0] addr_out,
    output logic [sdram_ui_pkg::CMD_WIDTH-1:0] cmd_out,
    output logic en_out,
    output logic [sdram_ui_pkg::APP_DATA_WIDTH-1:0] data_out,
    output logic [sdram_ui_pkg::APP_MASK_WIDTH-1:0] mask_out,
    output logic end_out,
    output logic wren_out
);
    timeunit 1ns;
    timeprecision 1ps;
    initial {addr_out, cmd_out, en_out, data_out, mask_out, end_out, wren_out} = '0;
    // Refused strobe stays up unchanged; released lines show inverted junk, except the write mask, which holds its value
    task automatic issue(input logic [2:0] c, input logic [ADDR_WIDTH-1:0] a);
        @(posedge clk_in);
        en_out <= 1'b1;
        cmd_out <= c;
        addr_out <= a;
        do @(negedge clk_in); while (rdy_in !== 1'b1);
        @(posedge clk_in);
        en_out <= 1'b0;
        cmd_out <= ~c;
        addr_out <= ~a;
    endtask
    task automatic beat(input logic [63:0] d, input logic [7:0] m, input logic e);
        @(posedge clk_in);
        wren_out <= 1'b1;
        data_out <= d;
        mask_out <= m;
        end_out <= e;
        do @(negedge clk_in); while (wdf_rdy_in !== 1'b1);
        @(posedge clk_in);
        wren_out <= 1'b0;
        data_out <= ~d;
        end_out <= ~e;
    endtask
endmodule // ui_requester
`default_nettype wire

// ===== verification/testbench.sv
`default_nettype none
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin error_cnt++; \
    $display("MISMATCH %s exp %h got %h", n, e, g); end end
module testbench
    import sdram_ui_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {logic [63:0] d; logic e;} note_t;
    note_t q[$];
    logic [63:0] mem [16];
    logic [63:0] fill [4];
    logic clk = 1'b0;
    logic rst = 1'b1;
    int checks = 0;
    int error_cnt = 0;
    logic [28:0] addr;
    logic [2:0] cmd;
    logic en, rdy, rv, re, wrdy, wend, wren, cal;
    logic [63:0] rdat, wdat;
    logic [7:0] msk;
    always #2.5 clk = ~clk;
    sdram_ui_port dut (.ref_clk_in(clk), .reset_in(rst), .req_addr_in(addr), .req_cmd_in(cmd),
        .req_en_in(en), .req_rdy_out(rdy), .req_priority_reserved_in(1'b0),
        .req_size_reserved_in(1'b0), .self_refresh_req_reserved_in(1'b0), .rd_data_out(rdat),
        .rd_data_end_out(re), .rd_data_valid_out(rv), .wdf_data_in(wdat), .wdf_end_in(wend),
        .wdf_mask_in(msk), .wdf_rdy_out(wrdy), .wdf_wren_in(wren), .calib_complete_out(cal),
        .user_side_reset_out());
    ui_requester host (.clk_in(clk), .rdy_in(rdy), .wdf_rdy_in(wrdy), .addr_out(addr),
        .cmd_out(cmd), .en_out(en), .data_out(wdat), .mask_out(msk), .end_out(wend),
        .wren_out(wren));
    task automatic complete_run;
        $display("checks %0d error_cnt %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic wr(input int w, input logic [7:0] m);
        logic [63:0] d0;
        logic [63:0] d1;
        d0 = {$urandom, $urandom};
        d1 = {$urandom, $urandom};
        host.beat(d0, m, 1'b0);
        host.beat(d1, m, 1'b1);
        host.issue(CMD_WRITE, {22'h0, w[3:0], 3'($urandom)});
        for (int b = 0; b < 8; b++) begin
            if (!m[b]) begin
                mem[w][b*8 +: 8] = d0[b*8 +: 8];
                mem[(w + 1) % 16][b*8 +: 8] = d1[b*8 +: 8];
            end
        end
    endtask
    task automatic rd(input int w);
        q.push_back('{mem[w], 1'b0});
        q.push_back('{mem[(w + 1) % 16], 1'b1});
        host.issue(CMD_READ, {22'h0, w[3:0], 3'($urandom)});
    endtask
    always @(negedge clk) begin
        if (rv === 1'b1) begin
            if (q.size() == 0) `CHK("spare beat", 1'b0, rv)
            else begin
                `CHK("rd_data", q[0].d, rdat)
                `CHK("rd_end", q[0].e, re)
                void'(q.pop_front());
            end
        end
    end
    initial begin
        #20us;
        error_cnt++;
        complete_run();
    end
    initial begin
        int i;
        void'($urandom(32'h4ebeec03));
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        for (i = 0; i < 500 && cal !== 1'b1; i++) @(negedge clk);
        `CHK("calib", 1'b1, cal)
        for (i = 0; i < 16; i += 2) wr(i, 8'h00);
        // All-ones mask leaves words 0 and 1 as they were
        wr(0, 8'hff);
        // Random mask: only the bytes with a clear mask bit change
        wr(6, 8'($urandom));
        for (i = 0; i < 4; i++) begin
            fill[i] = {$urandom, $urandom};
            host.beat(fill[i], 8'h00, 1'b1);
        end
        @(negedge clk);
        `CHK("wdf_rdy full", 1'b0, wrdy)
        for (i = 0; i < 4; i++) begin
            host.issue(CMD_WRITE, {22'h0, 4'(3 * i + 1), 3'h0});
            mem[3 * i + 1] = fill[i];
        end
        host.issue(3'h5, 29'h0);
        for (i = 0; i < 16; i += 2) rd(i);
        rd(15);
        repeat (10) @(negedge clk);
        `CHK("pending", 0, q.size())
        complete_run();
    end
endmodule // testbench
`default_nettype wire
